// file: design/mie_pkg.sv
// shared constants and types of the instruction execution block
// assumes one core clock; data file read port is combinational
package mie_pkg;

   // ************************************************************
   // widths
   // ************************************************************
   localparam int unsigned DATA_W  = 8;
   localparam int unsigned FADDR_W = 7;
   localparam int unsigned LIT_W   = 11;
   localparam int unsigned PC_W    = 13;
   localparam int unsigned SP_W    = 3;
   localparam int unsigned DEPTH   = 8;
   localparam int unsigned WDT_W   = 8;
   localparam int unsigned PRE_W   = 8;
   localparam int unsigned APB_AW  = 8;

   // ************************************************************
   // values and field positions
   // ************************************************************
   localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
   localparam logic [DATA_W-1:0] BYTE_ONE  = 8'h01;
   localparam logic [PC_W-1:0]   PC_ONE    = 13'h0001;
   localparam logic [SP_W-1:0]   SP_ONE    = 3'h1;
   localparam logic              FLAG_N_RST = 1'b1;
   localparam int unsigned LATCH_HI = 4;
   localparam int unsigned LATCH_LO = 3;
   localparam int unsigned ST_Z_BIT  = 0;
   localparam int unsigned ST_PD_BIT = 1;
   localparam int unsigned ST_TO_BIT = 2;
   localparam int unsigned CTRL_WDT_EN_BIT = 0;

   // ************************************************************
   // register byte offsets
   // ************************************************************
   localparam logic [APB_AW-1:0] OFS_WORK  = 8'h00;
   localparam logic [APB_AW-1:0] OFS_STAT  = 8'h04;
   localparam logic [APB_AW-1:0] OFS_PC    = 8'h08;
   localparam logic [APB_AW-1:0] OFS_LATCH = 8'h0C;
   localparam logic [APB_AW-1:0] OFS_WDT   = 8'h10;
   localparam logic [APB_AW-1:0] OFS_CTRL  = 8'h14;

   // ************************************************************
   // types
   // ************************************************************
   typedef enum logic [2:0] {
      OP_NOP, OP_WDCLR, OP_CALL, OP_COMPLEMENT_FILE_OP,
      OP_CLEAR_FILE_OP, OP_DECREMENT_FILE_OP, OP_CLEAR_WORKING_OP, OP_DSZ
   } mie_op_t;

   typedef enum logic [2:0] {
      RS_WORK, RS_STAT, RS_PC, RS_LATCH, RS_WDT, RS_CTRL, RS_NONE
   } mie_reg_t;

   typedef enum {ST_RUN, ST_FLUSH} mie_st_t;

   typedef struct packed {
      mie_op_t              op;
      logic [FADDR_W-1:0]   faddr;
      logic                 dest;
      logic [LIT_W-1:0]     lit;
   } mie_instr_t;

   typedef struct packed {
      logic                 we;
      logic [FADDR_W-1:0]   addr;
      logic [DATA_W-1:0]    data;
   } mie_fwr_t;

endpackage : mie_pkg

// file: design/mie_wdog.sv
// watchdog prescaler and counter
// assumes clear and enable are synchronous to the core clock
`timescale 1ns/1ps
`default_nettype none
module mie_wdog
   import mie_pkg::*;
(
   input  wire logic             clk,     // core clock
   input  wire logic             rst,     // sync reset, high
   input  wire logic             en,      // counting enable
   input  wire logic             clear,   // clear counter and prescaler
   output logic [WDT_W-1:0]      count,   // counter value
   output logic [PRE_W-1:0]      pre,     // prescaler value
   output logic                  timeout  // one-cycle overflow pulse
);
   typedef struct packed {
      logic [PRE_W-1:0] pre;
      logic [WDT_W-1:0] cnt;
      logic             to;
   } mie_wd_t;

   mie_wd_t r_reg;
   mie_wd_t r_next;

   // clear wins over counting so a clear never leaves a stale tick
   always_comb
   begin
      r_next    = r_reg;
      r_next.to = 1'b0;
      if (clear)
      begin
         r_next.pre = '0;
         r_next.cnt = '0;
      end
      else if (en)
      begin
         r_next.pre = r_reg.pre + 1'b1;
         if (&r_reg.pre)
         begin
            r_next.cnt = r_reg.cnt + 1'b1;
            r_next.to  = &r_reg.cnt;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         r_reg <= '0;
      else
         r_reg <= r_next;
   end

   assign count   = r_reg.cnt;
   assign pre     = r_reg.pre;
   assign timeout = r_reg.to;
endmodule : mie_wdog
`default_nettype wire

// file: design/mie_rstack.sv
// return address stack, circular, push only
// assumes overflow silently overwrites the oldest entry
`timescale 1ns/1ps
`default_nettype none
module mie_rstack
   import mie_pkg::*;
(
   input  wire logic             clk,    // core clock
   input  wire logic             rst,    // sync reset, high
   input  wire logic             push,   // push strobe
   input  wire logic [PC_W-1:0]  din,    // address pushed
   output logic [PC_W-1:0]       top     // newest entry
);
   typedef struct packed {
      logic [SP_W-1:0] sp;
   } mie_sk_t;

   mie_sk_t          r_reg;
   mie_sk_t          r_next;
   logic [PC_W-1:0]  mem [DEPTH];

   always_comb
   begin
      r_next = r_reg;
      if (push)
         r_next.sp = r_reg.sp + SP_ONE;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         r_reg <= '0;
      else
         r_reg <= r_next;
   end

   // entries carry no reset; only entries below sp are meaningful
   always_ff @(posedge clk)
   begin
      if (push)
         mem[r_reg.sp] <= din;
   end

   assign top = mem[r_reg.sp - SP_ONE];
endmodule : mie_rstack
`default_nettype wire

// file: design/mie_exec_top.sv
// execution of a subset of 8-bit core instructions, APB registers
// assumes fetch presents one decoded instruction per valid cycle and
// the data file returns FILE_RDATA for INSTR.faddr in the same cycle
//
// Contract
// [RULE1] watchdog clear loads the watchdog counter with zero
// [RULE2] watchdog clear also zeroes the watchdog prescaler
// [RULE3] watchdog clear sets timeout and power-down status bits high
// [RULE4] call pushes current address plus one onto stack top
// [RULE5] call loads literal into pc low bits, latch bits into pc top
// [RULE6] call takes two cycles, flags unchanged
// [RULE7] complement inverts file value, dest bit picks target, zero updated
// [RULE8] file clear writes zero to file register and sets zero flag
// [RULE9] decrement subtracts one, destination bit picks target, zero updated
// [RULE10] working clear writes zero to working register, sets zero flag
// [RULE11] decrement-skip writes file minus one to target, no flag change
// [RULE12] decrement-skip with zero result discards next instruction
// [RULE13] zero flag follows eight-bit result for complement and decrement
//
// Our own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module mie_exec_top
   import mie_pkg::*;
(
   input  wire logic                REF_CLK,     // core clock 25 MHz
   input  wire logic                SYS_RST,     // sync reset, high
   input  wire logic                PSEL,        // apb select
   input  wire logic                PENABLE,     // apb access phase
   input  wire logic                PWRITE,      // apb direction
   input  wire logic [APB_AW-1:0]   PADDR,       // apb byte address
   input  wire logic [31:0]         PWDATA,      // apb write data
   output logic [31:0]              PRDATA,      // apb read data
   output logic                     PREADY,      // apb ready
   output logic                     PSLVERR,     // apb error
   input  wire logic                INSTR_VALID, // instruction slot
   input  wire mie_pkg::mie_instr_t INSTR,       // decoded instruction
   input  wire logic [DATA_W-1:0]   FILE_RDATA,  // file value at faddr
   output mie_pkg::mie_fwr_t        FILE_WR,     // file write port
   output logic [PC_W-1:0]          PC_OUT,      // program counter
   output logic [PC_W-1:0]          STACK_TOP,   // return stack top
   output logic [DATA_W-1:0]        W_OUT,       // working register
   output logic                     Z_FLAG,      // zero flag
   output logic                     TO_N,        // timeout status, low
   output logic                     PD_N,        // power-down status, low
   output logic                     SKIP_ACTIVE, // discarding a slot
   output logic                     WDT_TIMEOUT  // watchdog overflow
);
   import mie_pkg::*;
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (SYS_RST);

   // ************************************************************
   // state
   // ************************************************************
   typedef struct packed {
      mie_st_t             st;
      logic                flush_inc;
      logic [DATA_W-1:0]   w;
      logic                z;
      logic                to_n;
      logic                pd_n;
      logic [PC_W-1:0]     pc;
      logic [DATA_W-1:0]   latch;
      logic                wdt_en;
      mie_fwr_t            fw;
      logic [31:0]         rdata;
      logic                slverr;
   } mie_exec_t;

   mie_exec_t          r_reg;
   mie_exec_t          r_next;
   logic               push;
   logic               wd_clear;
   logic [PC_W-1:0]    push_val;
   logic [WDT_W-1:0]   wd_count;
   logic [PRE_W-1:0]   wd_pre;
   logic               wd_to;
   logic               exec;

   // ************************************************************
   // register decode
   // ************************************************************
   // shared by the read mux and the write path
   function automatic mie_reg_t reg_sel(input logic [APB_AW-1:0] a);
      case (a)
         OFS_WORK:  reg_sel = RS_WORK;
         OFS_STAT:  reg_sel = RS_STAT;
         OFS_PC:    reg_sel = RS_PC;
         OFS_LATCH: reg_sel = RS_LATCH;
         OFS_WDT:   reg_sel = RS_WDT;
         OFS_CTRL:  reg_sel = RS_CTRL;
         default:   reg_sel = RS_NONE;
      endcase
   endfunction : reg_sel

   assign exec = INSTR_VALID && (r_reg.st == ST_RUN);

   // ************************************************************
   // next state
   // ************************************************************
   always_comb
   begin
      logic [DATA_W-1:0] res;
      logic              res_use;
      r_next     = r_reg;
      r_next.fw.we = 1'b0;
      push       = 1'b0;
      wd_clear   = 1'b0;
      push_val   = r_reg.pc + PC_ONE;
      res        = BYTE_ZERO;
      res_use    = 1'b0;
      // read data is captured in setup so it comes from a flop
      if (PSEL && !PENABLE)
      begin
         r_next.slverr = (reg_sel(PADDR) == RS_NONE);
         r_next.rdata  = '0;
         case (reg_sel(PADDR))
            RS_WORK:  r_next.rdata = 32'(r_reg.w);
            RS_STAT:
            begin
               r_next.rdata[ST_Z_BIT]  = r_reg.z;
               r_next.rdata[ST_PD_BIT] = r_reg.pd_n;
               r_next.rdata[ST_TO_BIT] = r_reg.to_n;
            end
            RS_PC:    r_next.rdata = 32'(r_reg.pc);
            RS_LATCH: r_next.rdata = 32'(r_reg.latch);
            RS_WDT:   r_next.rdata = 32'({wd_pre, wd_count});
            RS_CTRL:  r_next.rdata[CTRL_WDT_EN_BIT] = r_reg.wdt_en;
            default:  r_next.rdata = '0;
         endcase
      end
      // software writes; execution below overrides the working register
      if (PSEL && PENABLE && PWRITE)
      begin
         case (reg_sel(PADDR))
            RS_WORK:  r_next.w = PWDATA[DATA_W-1:0];
            RS_LATCH: r_next.latch = PWDATA[DATA_W-1:0];
            RS_CTRL:  r_next.wdt_en = PWDATA[CTRL_WDT_EN_BIT];
            default:  r_next.rdata = r_reg.rdata;
         endcase
      end
      // instruction execution
      case (r_reg.st)
         ST_RUN:
         begin
            if (INSTR_VALID)
            begin
               r_next.pc = r_reg.pc + PC_ONE;
               case (INSTR.op)
                  OP_WDCLR:
                  begin
                     wd_clear    = 1'b1;           // [RULE1] [RULE2]
                     r_next.to_n = 1'b1;           // [RULE3]
                     r_next.pd_n = 1'b1;           // [RULE3]
                  end
                  OP_CALL:
                  begin
                     push = 1'b1;                  // [RULE4]
                     r_next.pc = {r_reg.latch[LATCH_HI:LATCH_LO],
                                  INSTR.lit};      // [RULE5]
                     r_next.st = ST_FLUSH;         // [RULE6]
                     r_next.flush_inc = 1'b0;
                  end
                  OP_COMPLEMENT_FILE_OP:
                  begin
                     res     = ~FILE_RDATA;        // [RULE7]
                     res_use = 1'b1;
                     r_next.z = (res == BYTE_ZERO); // [RULE13]
                  end
                  OP_CLEAR_FILE_OP:
                  begin
                     r_next.fw.we   = 1'b1;        // [RULE8]
                     r_next.fw.addr = INSTR.faddr;
                     r_next.fw.data = BYTE_ZERO;
                     r_next.z       = 1'b1;        // [RULE8]
                  end
                  OP_DECREMENT_FILE_OP:
                  begin
                     res     = FILE_RDATA - BYTE_ONE; // [RULE9]
                     res_use = 1'b1;
                     r_next.z = (res == BYTE_ZERO);   // [RULE13]
                  end
                  OP_CLEAR_WORKING_OP:
                  begin
                     r_next.w = BYTE_ZERO;         // [RULE10]
                     r_next.z = 1'b1;              // [RULE10]
                  end
                  OP_DSZ:
                  begin
                     res     = FILE_RDATA - BYTE_ONE; // [RULE11]
                     res_use = 1'b1;
                     if (res == BYTE_ZERO)
                     begin
                        r_next.st = ST_FLUSH;      // [RULE12]
                        r_next.flush_inc = 1'b1;
                     end
                  end
                  default:
                     res_use = 1'b0;
               endcase
            end
         end
         ST_FLUSH:
         begin
            // the fetched slot is dropped; a skip still steps past it
            if (INSTR_VALID)
            begin
               r_next.st = ST_RUN;
               if (r_reg.flush_inc)
                  r_next.pc = r_reg.pc + PC_ONE;
            end
         end
         default:
            r_next.st = ST_RUN;
      endcase
      // destination bit: 0 working register, 1 file register
      if (res_use)
      begin
         if (INSTR.dest)
         begin
            r_next.fw.we   = 1'b1;                 // [RULE7] [RULE9]
            r_next.fw.addr = INSTR.faddr;
            r_next.fw.data = res;
         end
         else
            r_next.w = res;                        // [RULE11]
      end
      // a watchdog overflow is an event and wins over the clear
      if (wd_to)
         r_next.to_n = 1'b0;
   end

   always_ff @(posedge REF_CLK)
   begin
      if (SYS_RST)
      begin
         r_reg      <= '0;
         r_reg.st   <= ST_RUN;
         r_reg.to_n <= FLAG_N_RST;
         r_reg.pd_n <= FLAG_N_RST;
      end
      else
         r_reg <= r_next;
   end

   // ************************************************************
   // submodules
   // ************************************************************
   mie_wdog u_wdog (
      .clk     (REF_CLK),
      .rst     (SYS_RST),
      .en      (r_reg.wdt_en),
      .clear   (wd_clear),
      .count   (wd_count),
      .pre     (wd_pre),
      .timeout (wd_to)
   );

   mie_rstack u_stack (
      .clk  (REF_CLK),
      .rst  (SYS_RST),
      .push (push),
      .din  (push_val),
      .top  (STACK_TOP)
   );

   // ************************************************************
   // outputs
   // ************************************************************
   // zero wait states: every access completes in its first access cycle
   assign PREADY      = PSEL & PENABLE;
   assign PRDATA      = r_reg.rdata;
   assign PSLVERR     = PSEL & PENABLE & r_reg.slverr;
   assign FILE_WR     = r_reg.fw;
   assign PC_OUT      = r_reg.pc;
   assign W_OUT       = r_reg.w;
   assign Z_FLAG      = r_reg.z;
   assign TO_N        = r_reg.to_n;
   assign PD_N        = r_reg.pd_n;
   assign SKIP_ACTIVE = (r_reg.st == ST_FLUSH);
   assign WDT_TIMEOUT = wd_to;

   // ************************************************************
   // checks
   // ************************************************************
   a_wdclr_count: assert property ( // [RULE1]
      exec && INSTR.op == OP_WDCLR |=> wd_count == '0)
      else $error("watchdog counter not cleared");
   a_wdclr_pre: assert property ( // [RULE2]
      exec && INSTR.op == OP_WDCLR |=> wd_pre == '0)
      else $error("watchdog prescaler not cleared");
   a_wdclr_status: assert property ( // [RULE3]
      exec && INSTR.op == OP_WDCLR && !wd_to |=> TO_N && PD_N)
      else $error("status bits not set by watchdog clear");

   a_call_push: assert property ( // [RULE4]
      exec && INSTR.op == OP_CALL
      |=> STACK_TOP == $past(PC_OUT) + PC_ONE)
      else $error("call pushed wrong return address");

   a_call_target: assert property ( // [RULE5]
      exec && INSTR.op == OP_CALL
      |=> PC_OUT == {$past(r_reg.latch[LATCH_HI:LATCH_LO]),
                     $past(INSTR.lit)})
      else $error("call loaded wrong pc");

   a_call_two: assert property ( // [RULE6]
      exec && INSTR.op == OP_CALL
      |=> SKIP_ACTIVE && $stable(Z_FLAG))
      else $error("call not two cycles or flags moved");

   a_complement_file_op_work: assert property ( // [RULE7] [RULE13]
      exec && INSTR.op == OP_COMPLEMENT_FILE_OP && !INSTR.dest
      |=> W_OUT == ~$past(FILE_RDATA) && Z_FLAG == (W_OUT == BYTE_ZERO))
      else $error("complement result wrong");

   a_clear_file_op_zero: assert property ( // [RULE8]
      exec && INSTR.op == OP_CLEAR_FILE_OP
      |=> FILE_WR.we && FILE_WR.data == BYTE_ZERO && Z_FLAG)
      else $error("file clear wrong");

   a_decrement_file_op_file: assert property ( // [RULE9] [RULE13]
      exec && INSTR.op == OP_DECREMENT_FILE_OP && INSTR.dest
      |=> FILE_WR.we && FILE_WR.data == $past(FILE_RDATA) - BYTE_ONE
          && Z_FLAG == (FILE_WR.data == BYTE_ZERO))
      else $error("decrement result wrong");

   a_clear_working_op_zero: assert property ( // [RULE10]
      exec && INSTR.op == OP_CLEAR_WORKING_OP |=> W_OUT == BYTE_ZERO && Z_FLAG)
      else $error("working clear wrong");

   a_dsz_flags: assert property ( // [RULE11]
      exec && INSTR.op == OP_DSZ |=> $stable(Z_FLAG))
      else $error("decrement-skip changed a flag");

   a_dsz_skip: assert property ( // [RULE12]
      exec && INSTR.op == OP_DSZ
      |=> SKIP_ACTIVE == ($past(FILE_RDATA) == BYTE_ONE))
      else $error("decrement-skip skip decision wrong");
endmodule : mie_exec_top
`default_nettype wire

// file: verif/test_mcu_instr_exec_subset.sv
// bench of the instruction execution block with a reference model
// assumes the block stands alone; bench drives apb and the slot port
`timescale 1ns/1ps
`default_nettype none
module test_mcu_instr_exec_subset;
   import mie_pkg::*;
   logic              ref_clk = 1'h0;
   logic              sys_rst = 1'h1;
   logic              psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [APB_AW-1:0] paddr = 8'h00;
   logic [31:0]       pwdata = 32'h0, prdata, rd, r;
   logic              pready, pslverr, er, ivalid = 1'h0;
   mie_instr_t        instr = '0, pv = '0;
   logic [DATA_W-1:0] fdata = 8'h00, pv_f = 8'h00, f;
   mie_fwr_t          fwr;
   logic [PC_W-1:0]   pc_out, stack_top;
   logic [DATA_W-1:0] w_out;
   logic              z_flag, to_n, pd_n, skip_act, wdt_to;
   logic              pv_valid = 1'h0;
   int n_errors = 0, check_count = 0, seed = 7, n;
   // reference model state, plain integers
   int mw = 0, mz = 0, mpc = 0, mtop = 0, mskip = 0, minc = 0;
   int mlatch = 0, mto = 1, mpd = 1, ewe = 0, ead = 0, top_ok = 0;

   mie_exec_top dut_u (
      .REF_CLK(ref_clk), .SYS_RST(sys_rst), .PSEL(psel),
      .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
      .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .INSTR_VALID(ivalid), .INSTR(instr),
      .FILE_RDATA(fdata), .FILE_WR(fwr), .PC_OUT(pc_out),
      .STACK_TOP(stack_top), .W_OUT(w_out), .Z_FLAG(z_flag),
      .TO_N(to_n), .PD_N(pd_n), .SKIP_ACTIVE(skip_act),
      .WDT_TIMEOUT(wdt_to));

   // 25 MHz core clock
   always #20 ref_clk = ~ref_clk;

   task automatic check(input string nm, input logic [31:0] seen,
                        input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   task automatic conclude;
      if (n_errors == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : conclude

   // one apb transfer; request held until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd);
      @(posedge ref_clk);
      psel    <= 1'h1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge ref_clk);
      penable <= 1'h1;
      do @(posedge ref_clk); while (pready !== 1'h1);
      rd = prdata;
      er = pslverr;
      psel    <= 1'h0;
      penable <= 1'h0;
   endtask : apb

   // model of the slot sampled at this edge
   task automatic step;
      int res;
      ewe = 0;
      res = 0;
      if (!pv_valid)
         return;
      if (mskip)
      begin
         mskip = 0;
         mpc = (mpc + minc) % 8192;
         return;
      end
      case (pv.op)
         OP_WDCLR:
         begin
            mto = 1;
            mpd = 1;
         end
         OP_CALL:
         begin
            mtop = (mpc + 1) % 8192;
            top_ok = 1;
            mpc = ((mlatch >> 3) & 3) * 2048 + pv.lit;
            mskip = 1;
            minc = 0;
            return;
         end
         OP_COMPLEMENT_FILE_OP: res = ~pv_f & 255;
         OP_DECREMENT_FILE_OP, OP_DSZ: res = (pv_f + 255) % 256;
         default: res = 0;
      endcase
      if (pv.op inside {OP_COMPLEMENT_FILE_OP, OP_DECREMENT_FILE_OP, OP_DSZ} && !pv.dest)
         mw = res;
      if (pv.op inside {OP_COMPLEMENT_FILE_OP, OP_DECREMENT_FILE_OP, OP_DSZ} && pv.dest)
         ewe = 1;
      if (pv.op == OP_CLEAR_FILE_OP)
         ewe = 1;
      if (pv.op == OP_CLEAR_WORKING_OP)
         mw = 0;
      if (pv.op inside {OP_COMPLEMENT_FILE_OP, OP_DECREMENT_FILE_OP, OP_CLEAR_FILE_OP, OP_CLEAR_WORKING_OP})
         mz = (res == 0);
      if (pv.op == OP_DSZ && res == 0)
      begin
         mskip = 1;
         minc = 1;
      end
      ead = pv.faddr * 256 + res;
      mpc = (mpc + 1) % 8192;
   endtask : step

   // present one slot, then compare once the edge has landed
   task automatic issue(input mie_op_t op, input logic [6:0] fa,
                        input logic d, input logic [10:0] lit,
                        input logic [7:0] fd, input logic v);
      @(posedge ref_clk);
      step();
      ivalid <= v;
      instr  <= '{op, fa, d, lit};
      fdata  <= fd;
      pv_valid = v;
      pv = '{op, fa, d, lit};
      pv_f = fd;
      @(negedge ref_clk);
      check("w", w_out, mw);
      check("z", z_flag, mz);
      check("pc", pc_out, mpc);
      check("skip", skip_act, mskip);
      check("to", to_n, mto);
      check("pd", pd_n, mpd);
      check("we", fwr.we, ewe);
      if (ewe)
         check("fwr", {fwr.addr, fwr.data}, ead);
      if (top_ok)
         check("top", stack_top, mtop);
   endtask : issue

   // hang guard, about half again the expected run
   initial
   begin
      #(100000 * 40);
      n_errors++;
      conclude();
   end

   initial
   begin
      repeat (8) @(posedge ref_clk);
      sys_rst <= 1'h0;
      apb(1'h0, OFS_STAT, 32'h0);
      check("stat", rd, 32'h6);
      // unmapped place and read-only pc
      apb(1'h0, 8'h18, 32'h0);
      check("slverr", er, 32'h1);
      apb(1'h1, OFS_PC, 32'h1FFF);
      apb(1'h0, OFS_PC, 32'h0);
      check("pcreg", rd, mpc);
      apb(1'h1, OFS_WORK, 32'h5A);
      mw = 8'h5A;
      apb(1'h1, OFS_LATCH, 32'h18);
      mlatch = 8'h18;
      apb(1'h0, OFS_LATCH, 32'h0);
      check("latch", rd, mlatch);
      // call to the top page, the slot behind it must vanish
      issue(OP_CALL, 7'h00, 1'h0, 11'h7FF, 8'h00, 1'h1);
      issue(OP_COMPLEMENT_FILE_OP, 7'h10, 1'h0, 11'h000, 8'h00, 1'h1);
      issue(OP_NOP, 7'h00, 1'h0, 11'h000, 8'h00, 1'h1);
      // decrement-skip hitting zero, then wrapping below zero
      issue(OP_DSZ, 7'h05, 1'h1, 11'h000, 8'h01, 1'h1);
      issue(OP_CLEAR_WORKING_OP, 7'h00, 1'h0, 11'h000, 8'h00, 1'h1);
      issue(OP_DSZ, 7'h05, 1'h0, 11'h000, 8'h00, 1'h1);
      for (int i = 0; i < 400; i++)
      begin
         r = $random(seed);
         if (i % 50 == 0)
         begin
            issue(OP_NOP, 7'h00, 1'h0, 11'h000, 8'h00, 1'h0);
            apb(1'h1, OFS_LATCH, r);
            mlatch = r[7:0];
         end
         f = (r[5:4] == 2'h0) ? 8'h01 : (r[5:4] == 2'h1) ? 8'hFF : r[15:8];
         issue(mie_op_t'(r[2:0]), r[12:6], r[3], r[26:16], f,
               r[31:29] != 3'h0);
      end
      issue(OP_NOP, 7'h00, 1'h0, 11'h000, 8'h00, 1'h0);
      // run the watchdog to overflow, let it count, then clear it
      apb(1'h1, OFS_CTRL, 32'h1);
      n = 0;
      while (wdt_to !== 1'h1 && n < 70000)
      begin
         @(posedge ref_clk);
         n++;
      end
      check("wdt_ovf", n < 70000, 32'h1);
      mto = 0;
      repeat (300) @(posedge ref_clk);
      apb(1'h0, OFS_WDT, 32'h0);
      check("wdt_run", rd[7:0] != 8'h00, 32'h1);
      issue(OP_WDCLR, 7'h00, 1'h0, 11'h000, 8'h00, 1'h1);
      issue(OP_NOP, 7'h00, 1'h0, 11'h000, 8'h00, 1'h0);
      apb(1'h0, OFS_WDT, 32'h0);
      check("wdt_cnt", rd[7:0], 32'h0);
      check("wdt_pre", rd[15:8] < 8'h08, 32'h1);
      conclude();
   end
endmodule : test_mcu_instr_exec_subset
`default_nettype wire
